// ### attr_field_check.sv
`timescale 1ns/1ps
module attr_field_check
  import attr_table_pkg::*;
(
  input wire logic [7:0] field_i,
  output logic legal_o
);
  // only 00,01,04,05,06,07 are defined codes
  always_comb
  begin
    unique case (field_i)
      uncacheable_type, write_combining_type, write_through_type,
      write_protected_type, write_back_type,
      overridable_uncached_type: legal_o = 1'b1; // RULE5
      default: legal_o = 1'b0; // RULE6
    endcase
  end
endmodule

// ### attr_table_pkg.sv
// Contract
// [RULE1] feature flag bit 16 of edx reported for identification leaf 1
// [RULE2] no enable control; lookup always active whenever paging is on
// [RULE3] table is one 64-bit model register at fixed address 277h
// [RULE4] eight byte fields; low three bits type, high five reserved zero
// [RULE5] defined codes 00h, 01h, 04h, 05h, 06h, 07h, one memory type each
// [RULE6] write with code 02h, 03h or 08h-ffh raises general-protection fault
// [RULE7] faulting write leaves all eight fields unchanged
// [RULE8] index is high bit, cache-disable, write-through; selects field 0-7
// [RULE9] high bit 7 (4k) or 12 (large); disable bit 4, through bit 3
// [RULE10] selected field combined with range type gives effective type; the code has no range type and outputs the selected field type alone
// [RULE11] reset 0,4 back; 1,5 through; 2,6 weak uncached; 3,7 uncached
// [RULE12] soft initialization leaves the table unchanged
// [RULE13] read and write allowed only at privilege level 0
// [RULE14] software keeps caches and translation buffers consistent on change
// [RULE15] software never aliases one page with different memory types
// [RULE16] to remap cacheable as combining: unmap, flush buffers, map, flush
// [RULE17] table also used as directory may only select fields 0 to 3
// [RULE18] cache-disable and write-through bits never set the type directly
// [RULE19] software should keep fields 0 to 3 at reset values
package attr_table_pkg;
  localparam logic [31:0] page_attribute_table_addr = 32'h0000_0277;
  localparam logic [31:0] feature_leaf = 32'h0000_0001;
  localparam int feature_flag_bit = 16;
  localparam int field_width = 8;
  localparam int type_width = 3;
  localparam int field_count = 8;
  localparam int idx_high_small_pos = 7;
  localparam int idx_high_large_pos = 12;
  localparam int cache_disable_pos = 4;
  localparam int write_through_pos = 3;
  localparam logic [7:0] uncacheable_type = 8'h00;
  localparam logic [7:0] write_combining_type = 8'h01;
  localparam logic [7:0] write_through_type = 8'h04;
  localparam logic [7:0] write_protected_type = 8'h05;
  localparam logic [7:0] write_back_type = 8'h06;
  localparam logic [7:0] overridable_uncached_type = 8'h07;
  localparam logic [63:0] table_reset_value = {
    uncacheable_type, overridable_uncached_type,
    write_through_type, write_back_type,
    uncacheable_type, overridable_uncached_type,
    write_through_type, write_back_type};
endpackage

// ### memory_type_attribute_table.sv
`timescale 1ns/1ps
module memory_type_attribute_table
  import attr_table_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic soft_init_i,
  input wire logic msr_rd_i,
  input wire logic msr_wr_i,
  input wire logic [31:0] msr_addr_i,
  input wire logic [63:0] msr_wdata_i,
  input wire logic [1:0] current_privilege_level_i,
  input wire logic feat_req_i,
  input wire logic [31:0] feat_leaf_i,
  input wire logic lookup_valid_i,
  input wire logic [63:0] page_entry_i,
  input wire logic large_page_i,
  output logic [63:0] msr_rdata_o,
  output logic msr_done_o,
  output logic general_protection_fault_o,
  output logic feat_valid_o,
  output logic [31:0] feat_edx_o,
  output logic lookup_valid_o,
  output logic [2:0] entry_index_o,
  output logic [2:0] page_type_o
);
  logic [63:0] page_attribute_table;
  logic [63:0] next_table;
  logic [63:0] msr_rdata;
  logic [63:0] next_rdata;
  logic msr_done;
  logic next_done;
  logic fault_q;
  logic next_fault;
  logic feat_valid;
  logic [31:0] feat_edx;
  logic [31:0] next_edx;
  logic lk_valid;
  logic [2:0] lk_index;
  logic [2:0] lk_type;
  logic [2:0] next_index;
  logic [2:0] next_type;
  logic next_feat_valid;
  logic next_lk_valid;
  logic [2:0] sel_index;
  logic [type_width-1:0] sel_type;
  logic [type_width-1:0] field_type [field_count];
  logic [field_count-1:0] field_ok;
  logic all_ok;
  logic addr_hit;
  logic priv_ok;

  // per field: legality of the written byte and the stored type bits
  genvar g;
  generate
    for (g = 0; g < field_count; g++)
    begin : per_field
      attr_field_check u_chk (
        .field_i(msr_wdata_i[g*field_width +: field_width]),
        .legal_o(field_ok[g])
      );
      // reserved bits are always zero in the store, so only types travel
      assign field_type[g] =
        page_attribute_table[g*field_width +: type_width]; // RULE4
    end
  endgenerate

  assign all_ok = &field_ok;
  assign addr_hit = (msr_addr_i == page_attribute_table_addr); // RULE3
  assign priv_ok = (current_privilege_level_i == 2'h0); // RULE13

  // register access: validate, then store or fault
  always_comb
  begin
    next_table = page_attribute_table;
    next_rdata = msr_rdata;
    next_done = 1'b0;
    next_fault = 1'b0;
    if (msr_wr_i && addr_hit)
    begin
      next_done = 1'b1;
      if (priv_ok && all_ok)
        next_table = msr_wdata_i; // RULE4
      else
        next_fault = 1'b1; // RULE6 RULE7 RULE13
    end
    else if (msr_rd_i && addr_hit)
    begin
      next_done = 1'b1;
      if (priv_ok)
        next_rdata = page_attribute_table;
      else
        next_fault = 1'b1; // RULE13
    end
  end

  // table and access answer registers
  // soft_init_i deliberately not used here: only a hard reset reloads them
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      page_attribute_table <= table_reset_value; // RULE11
      msr_rdata <= 64'h0000_0000_0000_0000;
      msr_done <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      page_attribute_table <= next_table; // RULE12
      msr_rdata <= next_rdata;
      msr_done <= next_done;
      fault_q <= next_fault;
    end
  end

  // feature identification answer: edx held until the next request, valid flag follows feat_req_i one cycle later
  always_comb
  begin
    next_feat_valid = feat_req_i;
    next_edx = feat_edx;
    if (feat_req_i)
    begin
      next_edx = 32'h0000_0000;
      if (feat_leaf_i == feature_leaf)
        next_edx[feature_flag_bit] = 1'b1; // RULE1
    end
  end

  // feature answer registers
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      feat_valid <= 1'b0;
      feat_edx <= 32'h0000_0000;
    end
    else
    begin
      feat_valid <= next_feat_valid;
      feat_edx <= next_edx;
    end
  end

  // index formation and field select, no enable gate
  // cache-disable and write-through bits only index, they never pick a type
  always_comb
  begin
    if (large_page_i)
      sel_index[2] = page_entry_i[idx_high_large_pos]; // RULE9
    else
      sel_index[2] = page_entry_i[idx_high_small_pos]; // RULE9
    sel_index[1] = page_entry_i[cache_disable_pos]; // RULE9
    sel_index[0] = page_entry_i[write_through_pos]; // RULE9
    sel_type = field_type[sel_index]; // RULE2 RULE8 RULE18
    next_lk_valid = lookup_valid_i;
    next_index = lk_index;
    next_type = lk_type;
    if (lookup_valid_i)
    begin
      next_index = sel_index;
      next_type = sel_type; // RULE10
    end
  end

  // lookup answer registers
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lk_valid <= 1'b0;
      lk_index <= 3'h0;
      lk_type <= 3'h0;
    end
    else
    begin
      lk_valid <= next_lk_valid;
      lk_index <= next_index;
      lk_type <= next_type;
    end
  end

  // outputs straight from the answer registers
  assign msr_rdata_o = msr_rdata;
  assign msr_done_o = msr_done;
  assign general_protection_fault_o = fault_q;
  assign feat_valid_o = feat_valid;
  assign feat_edx_o = feat_edx;
  assign lookup_valid_o = lk_valid;
  assign entry_index_o = lk_index;
  assign page_type_o = lk_type;
endmodule

// ### memory_type_attribute_table_assertions.sv
`timescale 1ns/1ps
module tbl_chk (
  input logic clock_i,
  input logic rstn_i,
  input logic msr_rd_i,
  input logic msr_wr_i,
  input logic [31:0] msr_addr_i,
  input logic [1:0] current_privilege_level_i,
  input logic feat_req_i,
  input logic [31:0] feat_leaf_i,
  input logic lookup_valid_i,
  input logic [63:0] page_entry_i,
  input logic large_page_i,
  input logic [63:0] msr_rdata_o,
  input logic msr_done_o,
  input logic general_protection_fault_o,
  input logic feat_valid_o,
  input logic [31:0] feat_edx_o,
  input logic lookup_valid_o,
  input logic [2:0] entry_index_o,
  input logic [2:0] page_type_o
);
  // request to the table and the index a page entry should give
  wire a = (msr_rd_i || msr_wr_i) && msr_addr_i == 32'h0000_0277;
  wire [2:0] ix = {large_page_i ? page_entry_i[12] : page_entry_i[7],
    page_entry_i[4], page_entry_i[3]};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  AST_FEAT: assert property (feat_req_i |=> feat_valid_o &&
    feat_edx_o[16] == ($past(feat_leaf_i) == 32'h1)) else $error("flag");
  AST_DONE: assert property (a |=> msr_done_o) else $error("no done");
  AST_IGN: assert property (!a |=> !msr_done_o) else $error("done");
  AST_PRIV: assert property (a && current_privilege_level_i != 2'h0
    |=> general_protection_fault_o) else $error("privilege");
  AST_GPD: assert property (general_protection_fault_o |-> msr_done_o)
    else $error("fault alone");
  AST_HOLD: assert property (general_protection_fault_o |->
    $stable(msr_rdata_o)) else $error("data moved");
  AST_RSV: assert property ((msr_rdata_o & 64'hf8f8f8f8f8f8f8f8) == 0)
    else $error("reserved bits");
  AST_IDX: assert property (
    lookup_valid_i |=> lookup_valid_o && entry_index_o == $past(ix))
    else $error("index");
  AST_TYPE: assert property (lookup_valid_o |-> page_type_o inside
    {3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7}) else $error("type");
endmodule
bind memory_type_attribute_table tbl_chk u_tbl_chk (.*);

// ### memory_type_attribute_table_test.sv
`timescale 1ns/1ps
module memory_type_attribute_table_test;
  localparam logic [63:0] w = 64'h0406050100070406;
  logic clock_i = 1'b0, rstn_i = 1'b0, soft_init_i = 1'b0;
  logic msr_rd_i = 1'b0, msr_wr_i = 1'b0, feat_req_i = 1'b0;
  logic lookup_valid_i = 1'b0, large_page_i = 1'b0;
  logic [31:0] msr_addr_i = 32'h0, feat_leaf_i = 32'h0;
  logic [63:0] msr_wdata_i = 64'h0, page_entry_i = 64'h0, msr_rdata_o;
  logic [1:0] current_privilege_level_i = 2'h0;
  logic [31:0] feat_edx_o;
  logic [2:0] entry_index_o, page_type_o;
  logic msr_done_o, general_protection_fault_o, feat_valid_o;
  logic lookup_valid_o;
  int errors = 0, comparisons = 0;
  always #5 clock_i = ~clock_i;
  memory_type_attribute_table uut (.*);
  // compare, closing report
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one register access, answer checked one cycle later
  task automatic acc(input logic wr, input logic [31:0] a,
    input logic [63:0] d, input logic [1:0] p, input logic f);
    @(posedge clock_i);
    {msr_wr_i, msr_rd_i, msr_addr_i, msr_wdata_i} <= {wr, !wr, a, d};
    current_privilege_level_i <= p;
    @(posedge clock_i);
    {msr_wr_i, msr_rd_i} <= 2'h0;
    #1;
    chk({msr_done_o, general_protection_fault_o}, {a == 32'h277, f});
  endtask
  task automatic rd(input logic [63:0] e);
    acc(1'b0, 32'h277, 64'h0, 2'h0, 1'b0);
    chk(msr_rdata_o, e);
  endtask
  task automatic s_write();
    logic [63:0] e;
    acc(1'b1, 32'h277, w, 2'h0, 1'b0);
    rd(w);
    // each entry is a distinct page, none also walked as a directory
    for (int i = 0; i < 16; i++)
    begin
      e = 64'h0;
      {e[12], e[7], e[4], e[3]} = {i[2] ^ !i[3], i[2] ^ i[3], i[1:0]};
      @(posedge clock_i);
      {lookup_valid_i, page_entry_i, large_page_i} <= {1'b1, e, i[3]};
      @(posedge clock_i);
      lookup_valid_i <= 1'b0;
      #1;
      chk({lookup_valid_o, entry_index_o, page_type_o},
        {1'b1, i[2:0], w[8*i[2:0]+:3]});
    end
  endtask
  task automatic s_bad();
    logic [7:0] bc [4] = '{8'h02, 8'h03, 8'h08, 8'hff};
    logic [63:0] d;
    for (int k = 0; k < 4; k++)
    begin
      d = w;
      d[16*k+8+:8] = bc[k];
      acc(1'b1, 32'h277, d, 2'h0, 1'b1);
      rd(w);
    end
  endtask
  task automatic s_priv();
    acc(1'b1, 32'h277, 64'h0, 2'h3, 1'b1);
    acc(1'b0, 32'h277, 64'h0, 2'h1, 1'b1);
    rd(w);
  endtask
  task automatic s_misc();
    @(posedge clock_i);
    soft_init_i <= 1'b1;
    @(posedge clock_i);
    soft_init_i <= 1'b0;
    rd(w);
    acc(1'b1, 32'h278, 64'h0, 2'h0, 1'b0);
    rd(w);
    for (int l = 1; l < 3; l++)
    begin
      @(posedge clock_i);
      {feat_req_i, feat_leaf_i} <= {1'b1, l[31:0]};
      @(posedge clock_i);
      feat_req_i <= 1'b0;
      #1;
      chk({feat_valid_o, feat_edx_o[16]}, {1'b1, l == 1});
    end
  endtask
  // reset, scenarios, second reset after the last scenario
  initial
  begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(64'h0007040600070406);
    s_write();
    s_bad();
    s_priv();
    s_misc();
    @(posedge clock_i);
    rstn_i <= 1'b0;
    @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(64'h0007040600070406);
    wrap_up();
  end
endmodule
